// >>> shared/serial_port_pkg.sv
// Constants, types and register map of the serial port.
// Assumes a single core clock and synchronous pin inputs.
package serial_port_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'h98;
  localparam logic [7:0] BUF_ADDR = 8'h99;
  localparam logic [7:0] MATCH_ADDR = 8'hA9;
  localparam logic [7:0] MASK_ADDR = 8'hB9;
  localparam logic [7:0] POWER_ADDR = 8'h87;
  localparam logic [7:0] MATCH_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int MODE0_FAST_CLKS = 4;
  localparam int MODE0_SLOW_CLKS = 12;
  localparam int MODE2_FAST_CLKS = 32;
  localparam int MODE2_SLOW_CLKS = 64;
  localparam int OVERSAMPLE = 16;
  localparam logic [1:0] PRE_FAST_MAX = 2'(MODE2_FAST_CLKS / OVERSAMPLE - 1);
  localparam logic [1:0] PRE_SLOW_MAX = 2'(MODE2_SLOW_CLKS / OVERSAMPLE - 1);
  localparam logic [3:0] SAMPLE_FIRST = 4'h7;
  localparam logic [3:0] SAMPLE_LAST = 4'h9;
  localparam logic [3:0] BITS_MODE0 = 4'h8;
  localparam logic [3:0] BITS_TEN = 4'hA;
  localparam logic [3:0] BITS_ELEVEN = 4'hB;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic modeHigh;
    logic modeLow;
    logic multiproc;
    logic rxEnable;
    logic txNinth;
    logic rxNinth;
    logic txFlag;
    logic rxFlag;
  } ctrl_s;
  typedef struct packed {
    logic rateDouble;
    logic errorView;
  } power_s;
  typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC} tx_state_e;
  typedef enum logic [1:0] {RX_HUNT, RX_BITS, RX_SYNC} rx_state_e;
endpackage : serial_port_pkg

// >>> hdl/serial_port_addr_recog_fe.sv
// Serial port with four modes, framing error flag and address recognition.
// Assumes the register strobes and pins are synchronous to sys_clk.
// How it works
// - mode 3 is mode 2 at timer rate
// - writing the buffer starts transmission
// - mode 0 receive on clear flag, enabled
// - async receive begins on start bit
// - mode bits select frame format
// - rates 4/12, 32/64 clocks or timer
// - missing stop bit sets error flag
// - bit 7 shows error or mode bit
// - error flag sticky until software clears
// - modes 2/3 multiproc needs address match
// - multiproc off sets flag every frame
// - mode 1 multiproc needs stop and match
// - given address compares only masked bits
// - broadcast address is value OR mask
// - match value and mask reset zero
// - three mid samples, majority, start abort
// - load only when flag clear, condition met
// - start, eight data LSB first, ninth, stop
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module serial_port_addr_recog_fe
  import serial_port_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [7:0] rdData,
  input wire logic timerTick,
  input wire logic rxdIn,
  output logic rxdOut,
  output logic rxdOe,
  output logic txdOut
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic addrMatch(input logic [7:0] b, input logic [7:0] v, input logic [7:0] m);
    logic given;
    logic bcast;
    given = (((b ^ v) & m) == 8'h00);
    bcast = (((~b) & (v | m)) == 8'h00);
    return given | bcast;
  endfunction : addrMatch

  ctrl_s ctrl_r, ctrl_nxt;
  power_s pwr_r, pwr_nxt;
  tx_state_e txSt_r, txSt_nxt;
  rx_state_e rxSt_r, rxSt_nxt;
  logic fe_r, fe_nxt;
  logic [7:0] match_r, match_nxt, mask_r, mask_nxt, rxBuf_r, rxBuf_nxt, rdData_r, rdData_nxt;
  logic [10:0] txSh_r, txSh_nxt;
  logic [9:0] rxSh_r, rxSh_nxt;
  logic [3:0] txBits_r, txBits_nxt, txPh_r, txPh_nxt, rxBits_r, rxBits_nxt, rxPh_r, rxPh_nxt;
  logic [1:0] vote_r, vote_nxt, pre_r, pre_nxt;
  logic half_r, half_nxt, rxdPrev_r, txd_r, txd_nxt, rxdO_r, rxdO_nxt, oe_r, oe_nxt;
  logic [1:0] mode;
  logic [3:0] period, v3;
  logic tick, bufWr, ctrlWr, bitVal, rxDone, stopBit, flagBit, rxLoad, mode0Go;
  logic [7:0] rxByte;
  logic [9:0] shIn;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    pwr_nxt = pwr_r;
    fe_nxt = fe_r;
    match_nxt = match_r;
    mask_nxt = mask_r;
    rxBuf_nxt = rxBuf_r;
    txSt_nxt = txSt_r;
    txSh_nxt = txSh_r;
    txBits_nxt = txBits_r;
    txPh_nxt = txPh_r;
    rxSt_nxt = rxSt_r;
    rxSh_nxt = rxSh_r;
    rxBits_nxt = rxBits_r;
    rxPh_nxt = rxPh_r;
    vote_nxt = vote_r;
    pre_nxt = pre_r;
    half_nxt = half_r;
    rxDone = 1'b0;
    rxLoad = 1'b0;
    bitVal = 1'b0;
    rxByte = 8'h00;
    stopBit = 1'b1;
    flagBit = 1'b1;
    shIn = rxSh_r;
    v3 = 4'h0;
    mode = {ctrl_r.modeHigh, ctrl_r.modeLow};
    period = ctrl_r.multiproc ? 4'(MODE0_FAST_CLKS) : 4'(MODE0_SLOW_CLKS);
    // Oversampling tick; mode 3 differs from mode 2 only in this source.
    tick = 1'b0;
    if (mode == 2'h2)
    begin
      tick = (pre_r == (pwr_r.rateDouble ? PRE_FAST_MAX : PRE_SLOW_MAX));
      pre_nxt = tick ? 2'h0 : pre_r + 2'h1;
    end
    else if (timerTick)
    begin
      half_nxt = ~half_r;
      tick = pwr_r.rateDouble | half_r;
    end
    bufWr = wrEn && (addr == BUF_ADDR);
    ctrlWr = wrEn && (addr == CTRL_ADDR);
    // Software writes come first so that hardware sets below win a collision.
    if (ctrlWr)
    begin
      ctrl_nxt = ctrl_s'({ctrl_r.modeHigh, wrData[6:0]});
      if (pwr_r.errorView)
        fe_nxt = wrData[7];
      else
        ctrl_nxt.modeHigh = wrData[7];
    end
    if (wrEn && addr == POWER_ADDR)
      pwr_nxt = power_s'(wrData[7:6]);
    if (wrEn && addr == MATCH_ADDR)
      match_nxt = wrData;
    if (wrEn && addr == MASK_ADDR)
      mask_nxt = wrData;
    // ---------------- transmitter ----------------
    case (txSt_r)
      TX_ASYNC:
      begin
        if (tick)
        begin
          txPh_nxt = txPh_r + 4'h1;
          if (txPh_r == 4'hF)
          begin
            txSh_nxt = {1'b1, txSh_r[10:1]};
            txBits_nxt = txBits_r - 4'h1;
            if (txBits_r == 4'h1)
            begin
              txSt_nxt = TX_IDLE;
              ctrl_nxt.txFlag = 1'b1;
            end
          end
        end
      end
      TX_SYNC:
      begin
        txPh_nxt = txPh_r + 4'h1;
        if (txPh_r == period - 4'h1)
        begin
          txPh_nxt = 4'h0;
          txSh_nxt = {1'b1, txSh_r[10:1]};
          txBits_nxt = txBits_r - 4'h1;
          if (txBits_r == 4'h1)
          begin
            txSt_nxt = TX_IDLE;
            ctrl_nxt.txFlag = 1'b1;
          end
        end
      end
      default:
        txSt_nxt = TX_IDLE;
    endcase
    if (bufWr)
    begin
      txPh_nxt = 4'h0;
      if (mode == 2'h0)
      begin
        txSt_nxt = TX_SYNC;
        txSh_nxt = {3'b111, wrData};
        txBits_nxt = BITS_MODE0;
      end
      else
      begin
        txSt_nxt = TX_ASYNC;
        txSh_nxt = {1'b1, (mode == 2'h1) | ctrl_r.txNinth, wrData, 1'b0};
        txBits_nxt = (mode == 2'h1) ? BITS_TEN : BITS_ELEVEN;
      end
    end
    // ---------------- receiver ----------------
    mode0Go = (mode == 2'h0) && ctrl_r.rxEnable && !ctrl_r.rxFlag && (txSt_r == TX_IDLE) && !bufWr;
    case (rxSt_r)
      RX_HUNT:
      begin
        if (mode0Go)
        begin
          rxSt_nxt = RX_SYNC;
          rxPh_nxt = 4'h0;
          rxBits_nxt = 4'h0;
        end
        else if (mode != 2'h0 && ctrl_r.rxEnable && rxdPrev_r && !rxdIn)
        begin
          rxSt_nxt = RX_BITS;
          rxPh_nxt = 4'h0;
          rxBits_nxt = 4'h0;
          vote_nxt = 2'h0;
        end
      end
      RX_BITS:
      begin
        if (tick)
        begin
          rxPh_nxt = rxPh_r + 4'h1;
          v3 = {2'b00, vote_r} + {3'b000, rxdIn};
          if (rxPh_r >= SAMPLE_FIRST && rxPh_r < SAMPLE_LAST && rxdIn)
            vote_nxt = vote_r + 2'h1;
          if (rxPh_r == SAMPLE_LAST)
          begin
            bitVal = (v3 >= 4'h2);
            vote_nxt = 2'h0;
            rxBits_nxt = rxBits_r + 4'h1;
            if (rxBits_r == 4'h0)
            begin
              if (bitVal)
                rxSt_nxt = RX_HUNT;
            end
            else
            begin
              shIn = {bitVal, rxSh_r[9:1]};
              rxSh_nxt = shIn;
              if (rxBits_r == ((mode == 2'h1) ? BITS_TEN : BITS_ELEVEN) - 4'h1)
              begin
                rxDone = 1'b1;
                rxSt_nxt = RX_HUNT;
              end
            end
          end
        end
      end
      RX_SYNC:
      begin
        rxPh_nxt = rxPh_r + 4'h1;
        if (rxPh_r == period - 4'h1)
        begin
          rxPh_nxt = 4'h0;
          rxSh_nxt = {rxdIn, rxSh_r[9:1]};
          rxBits_nxt = rxBits_r + 4'h1;
          if (rxBits_r == BITS_MODE0 - 4'h1)
          begin
            rxSt_nxt = RX_HUNT;
            rxBuf_nxt = {rxdIn, rxSh_r[9:3]};
            ctrl_nxt.rxFlag = 1'b1;
          end
        end
      end
      default:
        rxSt_nxt = RX_HUNT;
    endcase
    if (rxDone)
    begin
      rxByte = (mode == 2'h1) ? shIn[8:1] : shIn[7:0];
      stopBit = shIn[9];
      flagBit = (mode == 2'h1) ? shIn[9] : shIn[8];
      // A failed match leaves buffer, ninth bit and flag alone.
      rxLoad = !ctrl_r.rxFlag && (!ctrl_r.multiproc || (flagBit && addrMatch(rxByte, match_r, mask_r)));
      if (rxLoad)
      begin
        rxBuf_nxt = rxByte;
        ctrl_nxt.rxNinth = flagBit;
        ctrl_nxt.rxFlag = 1'b1;
      end
      if (!stopBit)
        fe_nxt = 1'b1;
    end
    // ---------------- pins and read port ----------------
    txd_nxt = 1'b1;
    rxdO_nxt = 1'b1;
    oe_nxt = 1'b0;
    if (txSt_nxt == TX_ASYNC)
      txd_nxt = txSh_nxt[0];
    else if (txSt_nxt == TX_SYNC)
    begin
      txd_nxt = (txPh_nxt < (period >> 1));
      rxdO_nxt = txSh_nxt[0];
      oe_nxt = 1'b1;
    end
    else if (rxSt_nxt == RX_SYNC)
      txd_nxt = (rxPh_nxt < (period >> 1));
    rdData_nxt = 8'h00;
    if (rdEn)
    begin
      case (addr)
        CTRL_ADDR: rdData_nxt = {pwr_r.errorView ? fe_r : ctrl_r.modeHigh, ctrl_r[6:0]};
        BUF_ADDR: rdData_nxt = rxBuf_r;
        MATCH_ADDR: rdData_nxt = match_r;
        MASK_ADDR: rdData_nxt = mask_r;
        POWER_ADDR: rdData_nxt = {pwr_r, 6'h00};
        default: rdData_nxt = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r <= ctrl_s'(CTRL_RESET);
      pwr_r <= power_s'(2'h0);
      fe_r <= 1'b0;
      match_r <= MATCH_RESET;
      mask_r <= MASK_RESET;
      rxBuf_r <= 8'h00;
      rdData_r <= 8'h00;
      txSt_r <= TX_IDLE;
      rxSt_r <= RX_HUNT;
      txSh_r <= 11'h7FF;
      rxSh_r <= 10'h000;
      txBits_r <= 4'h0;
      txPh_r <= 4'h0;
      rxBits_r <= 4'h0;
      rxPh_r <= 4'h0;
      vote_r <= 2'h0;
      pre_r <= 2'h0;
      half_r <= 1'b0;
      rxdPrev_r <= 1'b1;
      txd_r <= 1'b1;
      rxdO_r <= 1'b1;
      oe_r <= 1'b0;
    end
    else if (clkEn)
    begin
      ctrl_r <= ctrl_nxt;
      pwr_r <= pwr_nxt;
      fe_r <= fe_nxt;
      match_r <= match_nxt;
      mask_r <= mask_nxt;
      rxBuf_r <= rxBuf_nxt;
      rdData_r <= rdData_nxt;
      txSt_r <= txSt_nxt;
      rxSt_r <= rxSt_nxt;
      txSh_r <= txSh_nxt;
      rxSh_r <= rxSh_nxt;
      txBits_r <= txBits_nxt;
      txPh_r <= txPh_nxt;
      rxBits_r <= rxBits_nxt;
      rxPh_r <= rxPh_nxt;
      vote_r <= vote_nxt;
      pre_r <= pre_nxt;
      half_r <= half_nxt;
      rxdPrev_r <= rxdIn;
      txd_r <= txd_nxt;
      rxdO_r <= rxdO_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign rdData = rdData_r;
  assign txdOut = txd_r;
  assign rxdOut = rxdO_r;
  assign rxdOe = oe_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Bit 7 as software should see it, held apart so that a read can be checked one cycle later.
  logic viewBit;
  assign viewBit = pwr_r.errorView ? fe_r : ctrl_r.modeHigh;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_tx_start_bit: assert property (clkEn && bufWr && mode != 2'h0 |=> txSt_r == TX_ASYNC && !txdOut)
    else $error("async write did not start a frame");
  a_fe_sticky: assert property (clkEn && fe_r && !ctrlWr |=> fe_r)
    else $error("framing error flag cleared by hardware");
  a_fe_set: assert property (clkEn && rxDone && !stopBit |=> fe_r)
    else $error("bad stop bit not flagged");
  a_load_match: assert property (clkEn && rxDone && ctrl_r.multiproc && !ctrl_r.rxFlag && !ctrlWr && !(flagBit && addrMatch(rxByte, match_r, mask_r)) |=> !ctrl_r.rxFlag)
    else $error("unmatched address raised the receive flag");
  a_full_hold: assert property (clkEn && rxDone && ctrl_r.rxFlag |=> $stable(rxBuf_r))
    else $error("buffer overwritten while flag set");
  a_every_frame: assert property (clkEn && rxDone && !ctrl_r.multiproc |=> ctrl_r.rxFlag)
    else $error("frame not flagged with multiproc off");
  a_mode0_rx: assert property (clkEn && rxSt_r == RX_HUNT && mode0Go |=> rxSt_r == RX_SYNC ##1 !rxdOe)
    else $error("mode 0 receive did not start");
  a_start_abort: assert property (clkEn && rxSt_r == RX_BITS && rxBits_r == 4'h0 && bitVal |=> rxSt_r == RX_HUNT)
    else $error("false start bit not aborted");
  a_view_read: assert property (clkEn && rdEn && addr == CTRL_ADDR && !ctrlWr |=> rdData[7] == $past(viewBit))
    else $error("bit 7 read from wrong flag");
  c_frame_loaded: cover property (rxLoad);
  c_frame_error: cover property (rxDone && !stopBit);
  c_addr_reject: cover property (rxDone && ctrl_r.multiproc && !rxLoad);
  c_mode0_done: cover property (rxSt_r == RX_SYNC ##1 rxSt_r == RX_HUNT);
endmodule : serial_port_addr_recog_fe

// >>> sim/serial_node.sv
// Far-side serial node: drives the data line into the port and decodes frames sent by it.
// Assumes bit periods are given in sys_clk cycles and that the line idles at the mark level.
`timescale 1ns/1ps
module serial_node
(
  input wire logic sys_clk,
  input wire logic lineIn,
  output logic lineOut
);
  initial lineOut = 1'b1;
  // Bits go out LSB first; the node adds no start bit of its own, the caller puts it in bit 0.
  task automatic sendFrame(input logic [10:0] bits, input int n, input int p);
    for (int i = 0; i < n; i++)
    begin
      lineOut <= bits[i];
      repeat (p) @(posedge sys_clk);
    end
    lineOut <= 1'b1;
  endtask : sendFrame
  // Samples mid-bit from the falling start edge; the wait is bounded so a silent port cannot hang it.
  task automatic recvFrame(input int n, input int p, output logic [10:0] bits);
    int t;
    bits = '0;
    t = 0;
    while (lineIn !== 1'b0 && t < 2000)
    begin
      @(posedge sys_clk);
      t++;
    end
    repeat (p / 2) @(posedge sys_clk);
    for (int i = 0; i < n; i++)
    begin
      bits[i] = lineIn;
      repeat (p) @(posedge sys_clk);
    end
  endtask : recvFrame
endmodule : serial_node

// >>> sim/testbench.sv
// Self-checking bench for the serial port: registers, frames both ways, error flag, address match.
// Assumes one far-side node on the pins and the plain strobe port for the registers.
`timescale 1ns/1ps
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin fail_count++; $display("wrong value %0t %s", $time, m); end end
module testbench;
  import serial_port_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wrData = 8'h00;
  logic wrEn = 1'b0;
  logic rdEn = 1'b0;
  logic timerTick = 1'b0;
  logic clkEn = 1'b1;
  logic [7:0] rdData;
  logic rxdOut, rxdOe, txdOut, nodeLine, rxdIn, n9, ex, prevClk;
  logic [7:0] rv, d, val, msk, lastBuf;
  logic [10:0] got, mk;
  int fail_count = 0;
  int n_checks = 0;
  int seedSet, cnt;
  always #5 sys_clk = ~sys_clk;
  // With rate doubling a tick every second clock gives 32 clocks a bit, the same as mode 2.
  always @(posedge sys_clk) timerTick <= ~timerTick;
  // The port's own drive wins over the node on the shared data pin.
  assign rxdIn = rxdOe ? rxdOut : nodeLine;
  serial_port_addr_recog_fe dut (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .addr(addr), .wrData(wrData),
    .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .timerTick(timerTick), .rxdIn(rxdIn), .rxdOut(rxdOut),
    .rxdOe(rxdOe), .txdOut(txdOut));
  serial_node node (.sys_clk(sys_clk), .lineIn(txdOut), .lineOut(nodeLine));
  // ----------------------------------------
  // Bus tasks and expectations
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    wrData <= v;
    wrEn <= 1'b1;
    @(posedge sys_clk);
    wrEn <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge sys_clk);
    rdEn <= 1'b0;
    #1 v = rdData;
  endtask : rd
  function automatic logic [10:0] frm(input logic [7:0] v, input logic b9, input logic stp, input int m);
    frm = (m == 1) ? {1'b1, stp, v, 1'b0} : {stp, b9, v, 1'b0};
  endfunction : frm
  function automatic logic hit(input logic [7:0] b, input logic [7:0] v, input logic [7:0] k);
    hit = (((b ^ v) & k) == 8'h00) || (((v | k) & ~b) == 8'h00);
  endfunction : hit
  task automatic rxOne(input logic [7:0] v, input logic b9, input logic stp, input int m);
    node.sendFrame(frm(v, b9, stp, m), (m == 1) ? 10 : 11, 32);
    repeat (4) @(posedge sys_clk);
  endtask : rxOne
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    fail_count++;
    end_sim();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    seedSet = $urandom(32'hC569C8AA);
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(MATCH_ADDR, rv);
    `CHK(rv, MATCH_RESET, "match reset")
    rd(MASK_ADDR, rv);
    `CHK(rv, MASK_RESET, "mask reset")
    rd(CTRL_ADDR, rv);
    `CHK(rv, CTRL_RESET, "control reset")
    rd(8'h55, rv);
    `CHK(rv, 8'h00, "unmapped read")
    wr(POWER_ADDR, 8'h80);
    for (int m = 1; m < 4; m++)
    begin
      n9 = 1'($urandom);
      d = 8'($urandom);
      mk = (m == 1) ? 11'h3FF : 11'h7FF;
      wr(CTRL_ADDR, {2'(m), 2'b01, n9, 3'b000});
      fork
        node.recvFrame((m == 1) ? 10 : 11, 32, got);
        wr(BUF_ADDR, d);
      join
      `CHK(got & mk, frm(d, n9, 1'b1, m) & mk, "frame sent")
      rd(CTRL_ADDR, rv);
      `CHK(rv[1], 1'b1, "tx flag")
      wr(CTRL_ADDR, {2'(m), 2'b01, 4'h0});
      d = 8'($urandom);
      n9 = 1'($urandom);
      rxOne(d, n9, 1'b1, m);
      rd(BUF_ADDR, rv);
      `CHK(rv, d, "frame received")
      rd(CTRL_ADDR, rv);
      `CHK(rv[2:0], {(m == 1) ? 1'b1 : n9, 2'b01}, "ninth bit and flag")
      rxOne(~d, n9, 1'b1, m);
      rd(BUF_ADDR, rv);
      `CHK(rv, d, "frame kept while flag set")
    end
    wr(CTRL_ADDR, 8'hD0);
    rxOne(8'h3C, 1'b0, 1'b0, 3);
    wr(POWER_ADDR, 8'hC0);
    rd(CTRL_ADDR, rv);
    `CHK(rv[7], 1'b1, "error flag set")
    wr(POWER_ADDR, 8'h80);
    wr(CTRL_ADDR, 8'hD0);
    rxOne(8'hA5, 1'b0, 1'b1, 3);
    wr(POWER_ADDR, 8'hC0);
    rd(CTRL_ADDR, rv);
    `CHK(rv[7], 1'b1, "error flag sticky")
    wr(CTRL_ADDR, 8'h50);
    rd(CTRL_ADDR, rv);
    `CHK(rv[7], 1'b0, "error flag cleared")
    wr(POWER_ADDR, 8'h80);
    rd(CTRL_ADDR, rv);
    `CHK(rv[7], 1'b1, "mode bit behind view")
    lastBuf = 8'hA5;
    for (int k = 0; k < 8; k++)
    begin
      val = (k == 0) ? 8'h00 : 8'($urandom);
      msk = (k == 0) ? 8'h00 : 8'($urandom);
      d = (k % 4 == 1) ? val : (k % 4 == 2) ? 8'hFF : (k % 4 == 3) ? val ^ (msk & (~msk + 8'h01)) : 8'($urandom);
      wr(MATCH_ADDR, val);
      wr(MASK_ADDR, msk);
      rd(MATCH_ADDR, rv);
      `CHK(rv, val, "match readback")
      wr(CTRL_ADDR, 8'hB0);
      ex = hit(d, val, msk);
      rxOne(d, 1'b1, 1'b1, 2);
      rd(CTRL_ADDR, rv);
      `CHK(rv[0], ex, "address flag")
      if (ex)
        lastBuf = d;
      rd(BUF_ADDR, rv);
      `CHK(rv, lastBuf, "buffer after address")
    end
    wr(CTRL_ADDR, 8'hB0);
    rxOne(8'h5A, 1'b0, 1'b1, 2);
    rd(CTRL_ADDR, rv);
    `CHK(rv[0], 1'b0, "data byte ignored")
    // A zero mask makes every byte a match, so only the stop bit decides below.
    wr(MASK_ADDR, 8'h00);
    for (int s = 0; s < 2; s++)
    begin
      wr(CTRL_ADDR, 8'h70);
      rxOne(8'h11, 1'b0, 1'(s), 1);
      rd(CTRL_ADDR, rv);
      `CHK(rv[0], 1'(s), "mode 1 stop bit")
    end
    wr(CTRL_ADDR, 8'h90);
    node.sendFrame(11'h000, 1, 4);
    repeat (400) @(posedge sys_clk);
    rd(CTRL_ADDR, rv);
    `CHK(rv[0], 1'b0, "short start aborted")
    // Both shift rates: 12 clocks a bit with multiproc clear, 4 with it set.
    for (int q = 0; q < 2; q++)
    begin
      wr(CTRL_ADDR, q ? 8'h20 : 8'h00);
      d = 8'($urandom);
      wr(BUF_ADDR, d);
      cnt = 0;
      prevClk = 1'b1;
      repeat (120)
      begin
        @(posedge sys_clk);
        #1;
        if (prevClk === 1'b1 && txdOut === 1'b0 && cnt < 8)
        begin
          got[cnt] = rxdOut;
          `CHK(rxdOe, 1'b1, "data pin driven")
          cnt++;
        end
        prevClk = txdOut;
      end
      `CHK(got[7:0], d, "sync frame")
    end
    wr(CTRL_ADDR, 8'h30);
    repeat (100) @(posedge sys_clk);
    rd(BUF_ADDR, rv);
    `CHK(rv, 8'hFF, "sync receive")
    rd(CTRL_ADDR, rv);
    `CHK(rv[0], 1'b1, "sync receive flag")
    // A write taken while the clock enable is low must not land.
    clkEn <= 1'b0;
    wr(MATCH_ADDR, ~val);
    clkEn <= 1'b1;
    rd(MATCH_ADDR, rv);
    `CHK(rv, val, "write frozen by clock enable")
    end_sim();
  end
endmodule : testbench
